//--- rtl/option_regs_pkg.sv
// ============================================================================
// Option register package
// ============================================================================
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: 25 MHz system clock
// Notes:   Shared by the option register bank and its millisecond timers
`default_nettype none

package option_regs_pkg;

  // ==========================================================================
  // Register offsets and reset values
  // ==========================================================================
  localparam logic [7:0] REG_ENABLE_OFFSET   = 8'h67;  // Regulator enable register
  localparam logic [7:0] IFACE_OPT_OFFSET    = 8'h7c;  // Interface and protection options
  localparam logic [7:0] CURRENT_OPT_OFFSET  = 8'h7d;  // Current limit and mask options
  localparam logic [7:0] IFACE_OPT_RESET     = 8'h00;
  localparam logic [7:0] CURRENT_OPT_RESET   = 8'h00;
  localparam logic [3:0] REG_ENABLE_RESET    = 4'h0;

  // ==========================================================================
  // Field positions, interface and protection options
  // ==========================================================================
  localparam int ADDR_SELECT_BIT    = 7;  // Bus address low bits select
  localparam int MANUAL_CTRL_BIT    = 6;  // Bus control of regulators
  localparam int PERSIST_FILTER_BIT = 5;  // Window fault persistence filter
  localparam int CRC_ENABLE_BIT     = 4;  // Transaction check bytes
  localparam int SHORT_WAIT_BIT     = 3;  // Short reset-low and restart wait
  localparam int NEG_THRESH_BIT     = 2;  // Negative current threshold select
  localparam int FIRST_LIM_HI_BIT   = 1;  // First current limit high bit
  localparam int FIRST_LIM_LO_BIT   = 0;  // First current limit low bit

  // Field positions, current limit and mask options
  localparam int THIRD_LIM_LSB      = 6;  // Third buck limit field
  localparam int SECOND_LIM_LSB     = 4;  // Second buck limit field
  localparam int PG_IGNORE_LSB      = 0;  // Power-good ignore field

  // Bus address
  localparam logic [4:0] ADDR_UPPER    = 5'h13;  // Fixed upper bits 10011
  localparam logic [1:0] ADDR_LOW_CLR  = 2'h1;   // Low bits when select clear
  localparam logic [1:0] ADDR_LOW_SET  = 2'h2;   // Low bits when select set

  // Output index in power-good and enable vectors
  localparam int OUT_BUCK1 = 0;
  localparam int OUT_BUCK2 = 1;
  localparam int OUT_BUCK3 = 2;
  localparam int OUT_LDO   = 3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 40;
  localparam int NS_PER_MS      = 1000000;
  localparam int CYCLES_PER_MS  = NS_PER_MS / CLK_PERIOD_NS;
  localparam int LONG_WAIT_MS   = 200;  // Long reset-low and wait time
  localparam int SHORT_WAIT_MS  = 20;   // Short reset-low and wait time
  localparam int FILTER_MS      = 30;   // Persistence filter time
  localparam int MS_WIDTH       = 8;    // Width of millisecond counters

  // ==========================================================================
  // Decoded current limits
  // ==========================================================================
  typedef enum logic [1:0] {HV_LIM_1P50, HV_LIM_1P20, HV_LIM_1P75} hv_limit_t;
  typedef enum logic [1:0] {LV_LIM_1P20, LV_LIM_0P96, LV_LIM_1P56} lv_limit_t;

endpackage : option_regs_pkg

`default_nettype wire

//--- rtl/ms_countdown.sv
// ============================================================================
// Millisecond countdown
// ============================================================================
// Purpose: Loadable down-counter advanced by a one-cycle millisecond tick
// Assumes: Tick is a single-cycle enable on the same clock
// Notes:   Load wins over counting; busy while the count is non-zero
`default_nettype none

module ms_countdown
  import option_regs_pkg::*;
#(
  parameter int WIDTH = MS_WIDTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_ms,
  input  wire logic             tick,
  // Status
  output logic                  busy
);

  logic [WIDTH-1:0] count;       // Remaining milliseconds
  logic [WIDTH-1:0] next_count;  // Next remaining milliseconds

  // Next count: load, else step down on tick
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_ms;
    end else if (tick && count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  // Count register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);

  // Count steps down exactly one per tick
  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && !load && count != '0) |=> count == $past(count) - WIDTH'(1))
    else $error("countdown did not step by one");

endmodule : ms_countdown

`default_nettype wire

//--- rtl/option_registers.sv
// ============================================================================
// Option register bank
// ============================================================================
// Purpose: Two option registers, regulator enable register, reset output
// Assumes: Register port driven by the bus engine on the same clock
// Notes:   Window and shutdown inputs come from analog and are synchronised
`default_nettype none

module option_registers
  import option_regs_pkg::*;
#(
  parameter int TICK_CYCLES = CYCLES_PER_MS  // Cycles per millisecond tick
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Register port from bus engine
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Factory option load
  input  wire logic       otp_load,
  input  wire logic [7:0] otp_iface_opt,
  input  wire logic [7:0] otp_current_opt,
  // Monitors and fault manager
  input  wire logic       seq_option,
  input  wire logic [3:0] power_good,
  input  wire logic       output_shutdown,
  input  wire logic       window_watchdog_fault,
  input  wire logic       sequence_fault,
  input  wire logic       other_fault,
  input  wire logic       enable_release,
  input  wire logic [3:0] sequencer_regulator_on,
  // Configuration outputs
  output logic      [6:0] bus_address,
  output logic            crc_enable,
  output logic            sequencer_disable,
  output logic      [3:0] regulator_on,
  output logic            negative_current_threshold_select,
  output hv_limit_t       first_limit,
  output lv_limit_t       second_buck_current_limit,
  output lv_limit_t       third_buck_current_limit,
  output logic      [3:0] power_good_ignore,
  // Reset and restart
  output logic            rst_out_n,
  output logic            restart_wait
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Decode functions
  // ==========================================================================
  // Buck current limit: 0x, 10, 11
  function automatic lv_limit_t lv_decode(input logic [1:0] code);
    if (!code[1]) begin
      return LV_LIM_1P20;
    end else if (!code[0]) begin
      return LV_LIM_0P96;
    end else begin
      return LV_LIM_1P56;
    end
  endfunction

  // True when a register access hits the given offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] iface_opt;         // Interface and protection options
  logic [7:0] current_opt;       // Current limit and mask options
  logic [3:0] reg_enable;        // Regulator enable register bits 3:0
  logic [7:0] next_iface_opt;
  logic [7:0] next_current_opt;
  logic [3:0] next_reg_enable;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // Next register values; factory load wins over bus writes
  always_comb begin
    next_iface_opt   = iface_opt;
    next_current_opt = current_opt;
    next_reg_enable  = reg_enable;
    next_rdata       = reg_rdata;
    next_rvalid      = 1'b0;
    if (otp_load) begin
      // Factory load may set the manual bit
      next_iface_opt   = otp_iface_opt;
      next_current_opt = {otp_current_opt[7:4], 2'h0, otp_current_opt[1:0]};
    end else if (reg_write) begin
      if (hit(reg_addr, IFACE_OPT_OFFSET)) begin
        // Bus write keeps the manual bit as it is
        next_iface_opt = reg_wdata;
        next_iface_opt[MANUAL_CTRL_BIT] = iface_opt[MANUAL_CTRL_BIT];
      end
      if (hit(reg_addr, CURRENT_OPT_OFFSET)) begin
        // Reserved bits 3:2 stay zero
        next_current_opt = {reg_wdata[7:4], 2'h0, reg_wdata[1:0]};
      end
      if (hit(reg_addr, REG_ENABLE_OFFSET) && iface_opt[MANUAL_CTRL_BIT]) begin
        // Bus control of regulators only in manual mode
        next_reg_enable = reg_wdata[3:0];
      end
    end
    if (reg_read) begin
      // Read data, unmapped offsets read zero
      next_rvalid = 1'b1;
      if (hit(reg_addr, IFACE_OPT_OFFSET)) begin
        next_rdata = iface_opt;
      end else if (hit(reg_addr, CURRENT_OPT_OFFSET)) begin
        next_rdata = current_opt;
      end else if (hit(reg_addr, REG_ENABLE_OFFSET)) begin
        next_rdata = {4'h0, reg_enable};
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      iface_opt   <= IFACE_OPT_RESET;
      current_opt <= CURRENT_OPT_RESET;
      reg_enable  <= REG_ENABLE_RESET;
      reg_rdata   <= 8'h00;
      reg_rvalid  <= 1'b0;
    end else begin
      iface_opt   <= next_iface_opt;
      current_opt <= next_current_opt;
      reg_enable  <= next_reg_enable;
      reg_rdata   <= next_rdata;
      reg_rvalid  <= next_rvalid;
    end
  end

  // ==========================================================================
  // Configuration decode
  // ==========================================================================
  logic       filter_en;   // Persistence filter enabled
  logic       short_wait;  // 20ms instead of 200ms
  logic [1:0] ignore_sel;  // Power-good ignore field

  assign filter_en  = iface_opt[PERSIST_FILTER_BIT];
  assign short_wait = iface_opt[SHORT_WAIT_BIT];
  assign ignore_sel = current_opt[PG_IGNORE_LSB +: 2];

  // Address low bits chosen by the select bit
  assign bus_address = {ADDR_UPPER,
                        iface_opt[ADDR_SELECT_BIT] ? ADDR_LOW_SET : ADDR_LOW_CLR};
  assign crc_enable = iface_opt[CRC_ENABLE_BIT];
  assign sequencer_disable = iface_opt[MANUAL_CTRL_BIT];
  // Regulators from bus register in manual mode, else from sequencer
  assign regulator_on = sequencer_disable ? reg_enable : sequencer_regulator_on;
  // Severe low-side threshold is fixed, only negative threshold moves
  assign negative_current_threshold_select = iface_opt[NEG_THRESH_BIT];
  assign second_buck_current_limit = lv_decode(current_opt[SECOND_LIM_LSB +: 2]);
  assign third_buck_current_limit  = lv_decode(current_opt[THIRD_LIM_LSB +: 2]);

  // First current limit: 00, x1, 10
  always_comb begin
    if (iface_opt[FIRST_LIM_LO_BIT]) begin
      first_limit = HV_LIM_1P20;
    end else if (iface_opt[FIRST_LIM_HI_BIT]) begin
      first_limit = HV_LIM_1P75;
    end else begin
      first_limit = HV_LIM_1P50;
    end
  end

  // Cumulative ignore mask, order set by sequence option
  always_comb begin
    power_good_ignore = 4'h0;
    if (!seq_option) begin
      power_good_ignore[OUT_LDO]   = (ignore_sel >= 2'h1);
      power_good_ignore[OUT_BUCK3] = (ignore_sel >= 2'h2);
      power_good_ignore[OUT_BUCK2] = (ignore_sel == 2'h3);
    end else begin
      power_good_ignore[OUT_BUCK3] = (ignore_sel >= 2'h1);
      power_good_ignore[OUT_BUCK2] = (ignore_sel >= 2'h2);
      power_good_ignore[OUT_LDO]   = (ignore_sel == 2'h3);
    end
  end

  // ==========================================================================
  // Analog input synchronisers
  // ==========================================================================
  logic [4:0] sync_meta;  // First stage
  logic [4:0] sync_out;   // Second stage
  logic [3:0] pg_sync;    // Synchronised power-good
  logic       shut_sync;  // Synchronised output shutdown

  // Two flip-flops per analog level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_meta <= 5'h0f;
      sync_out  <= 5'h0f;
    end else begin
      sync_meta <= {output_shutdown, power_good};
      sync_out  <= sync_meta;
    end
  end

  assign pg_sync   = sync_out[3:0];
  assign shut_sync = sync_out[4];

  // ==========================================================================
  // Millisecond tick and timers
  // ==========================================================================
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic [TW-1:0] div_count;       // Tick divider
  logic [TW-1:0] next_div_count;
  logic          ms_tick;         // One-cycle millisecond enable

  // Divider next value
  always_comb begin
    ms_tick        = (div_count == TW'(TICK_CYCLES - 1));
    next_div_count = ms_tick ? '0 : div_count + TW'(1);
  end

  // Divider register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_count <= '0;
    end else begin
      div_count <= next_div_count;
    end
  end

  logic                wait_fault;   // Watchdog or sequence fault
  logic [MS_WIDTH-1:0] sel_ms;       // Selected wait duration
  logic [MS_WIDTH-1:0] pulse_ms;     // Reset pulse duration
  logic                pulse_busy;   // Reset-low pulse running
  logic                window_fault; // Non-ignored output out of window
  logic                filter_busy;  // Persistence not yet reached
  logic                filtered;     // Window fault after filtering

  assign wait_fault = window_watchdog_fault | sequence_fault;
  assign sel_ms = short_wait ? MS_WIDTH'(SHORT_WAIT_MS) : MS_WIDTH'(LONG_WAIT_MS);
  // Other faults always take the long pulse
  assign pulse_ms = other_fault ? MS_WIDTH'(LONG_WAIT_MS) : sel_ms;

  // Reset-low pulse after a watchdog, sequence or other fault event
  ms_countdown #(.WIDTH(MS_WIDTH)) u_pulse (
    .clk     (clk),
    .arst_n  (arst_n),
    .load    (wait_fault | other_fault),
    .load_ms (pulse_ms),
    .tick    (ms_tick),
    .busy    (pulse_busy)
  );

  // Hiccup wait and enable restart lockout share the selected time
  ms_countdown #(.WIDTH(MS_WIDTH)) u_restart (
    .clk     (clk),
    .arst_n  (arst_n),
    .load    (wait_fault | enable_release),
    .load_ms (sel_ms),
    .tick    (ms_tick),
    .busy    (restart_wait)
  );

  // Persistence filter, held loaded while no window fault
  ms_countdown #(.WIDTH(MS_WIDTH)) u_filter (
    .clk     (clk),
    .arst_n  (arst_n),
    .load    (!window_fault),
    .load_ms (MS_WIDTH'(FILTER_MS)),
    .tick    (ms_tick),
    .busy    (filter_busy)
  );

  assign window_fault = |(~pg_sync & ~power_good_ignore);
  assign filtered = window_fault && !(filter_en && filter_busy);
  // Shutdown bypasses the filter
  assign rst_out_n = !(pulse_busy || filtered || shut_sync);

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_addr_select: assert property (
    (reg_write && !otp_load && hit(reg_addr, IFACE_OPT_OFFSET))
    |=> bus_address[1:0] == ($past(reg_wdata[7]) ? ADDR_LOW_SET : ADDR_LOW_CLR))
    else $error("bus address low bits wrong");
  // Manual mode: a bus write to the enable register reaches the regulators
  a_manual_route: assert property ((sequencer_disable && reg_write && !otp_load
    && hit(reg_addr, REG_ENABLE_OFFSET)) |=> regulator_on == $past(reg_wdata[3:0]))
    else $error("regulator control source wrong");
  a_manual_locked: assert property ((!sequencer_disable && !otp_load)
    |=> !sequencer_disable)
    else $error("manual bit set without factory load");
  a_filter_hold: assert property ((filter_en && $rose(window_fault) && !pulse_busy
    && !shut_sync) |-> rst_out_n)
    else $error("filter did not delay reset");
  // Shutdown pin held through the synchroniser forces reset low
  a_shutdown_now: assert property (output_shutdown [*4] |-> !rst_out_n)
    else $error("shutdown did not drive reset low");
  a_crc_follow: assert property (
    (reg_write && !otp_load && hit(reg_addr, IFACE_OPT_OFFSET))
    |=> crc_enable == $past(reg_wdata[4]))
    else $error("check-byte enable wrong");
  a_other_pulse: assert property (other_fault |=> !rst_out_n [*8])
    else $error("reset pulse too short");
  a_wait_start: assert property (wait_fault |=> !rst_out_n && restart_wait)
    else $error("fault wait not started");
  a_lockout_start: assert property (enable_release |=> restart_wait)
    else $error("restart lockout not started");
  // Steady non-ignored power-good loss at the pins, filter off
  a_pg_reset: assert property (
    (!filter_en && |(~power_good & ~power_good_ignore) && $stable(power_good)
    && $stable(power_good_ignore)) [*4] |-> !rst_out_n)
    else $error("power-good loss missed");

endmodule : option_registers

`default_nettype wire

//--- test/reg_master_model.sv
// ============================================================================
// Register port master model
// ============================================================================
// Purpose: Bus engine stand-in issuing single writes and reads
// Assumes: One-cycle strobes, answer registered on the taking edge
// Notes:   Data lines are inverted between transfers so stale values never match
`default_nettype none

module reg_master_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels from time zero
  initial begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One write strobe, then scramble the data lines
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  // One read strobe, data and valid taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // reg_master_model

`default_nettype wire

//--- test/test_option_registers.sv
// ============================================================================
// Option register bank testbench
// ============================================================================
// Purpose: Registers, decodes, fault timing and reset output masking
// Assumes: Millisecond tick shortened to 4 cycles
// Notes:   Pulse lengths accept one tick of phase slack
`default_nettype none

module test_option_registers
  import option_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICK = 4;  // Cycles per ms tick

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic       clk, arst_n, reg_write, reg_read, reg_rvalid, otp_load, seq_option;
  logic       output_shutdown, wdt, seq_f, oth_f, en_rel;
  logic       crc_enable, sequencer_disable, neg_sel, rst_out_n, restart_wait;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, otp_iface, otp_cur, rdv;
  logic [3:0] power_good, seq_on, regulator_on, power_good_ignore;
  logic [6:0] bus_address;
  logic       vld;
  hv_limit_t  first_limit;
  lv_limit_t  lim2, lim3;
  int         n_fail, tests_run, cyc;

  // Ignore masks by {seq_option, code}
  localparam logic [3:0] PGM [8] = '{4'h0, 4'h8, 4'hc, 4'he, 4'h0, 4'h4, 4'h6, 4'he};

  always #20 clk = ~clk;

  // ==========================================================================
  // Instances
  // ==========================================================================
  option_registers #(.TICK_CYCLES(TICK)) u_option_registers (
    .clk(clk), .arst_n(arst_n), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .otp_load(otp_load), .otp_iface_opt(otp_iface),
    .otp_current_opt(otp_cur), .seq_option(seq_option), .power_good(power_good),
    .output_shutdown(output_shutdown), .window_watchdog_fault(wdt),
    .sequence_fault(seq_f), .other_fault(oth_f), .enable_release(en_rel),
    .sequencer_regulator_on(seq_on), .bus_address(bus_address),
    .crc_enable(crc_enable), .sequencer_disable(sequencer_disable),
    .regulator_on(regulator_on), .negative_current_threshold_select(neg_sel),
    .first_limit(first_limit), .second_buck_current_limit(lim2),
    .third_buck_current_limit(lim3), .power_good_ignore(power_good_ignore),
    .rst_out_n(rst_out_n), .restart_wait(restart_wait));

  reg_master_model u_reg_master_model (
    .clk(clk), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Wait some clock cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle fault event: 0 watchdog, 1 sequence, 2 other, 3 enable release
  task automatic fire(input int e);
    @(posedge clk);
    case (e)
      0: wdt <= 1'b1;
      1: seq_f <= 1'b1;
      2: oth_f <= 1'b1;
      default: en_rel <= 1'b1;
    endcase
    @(posedge clk);
    {wdt, seq_f, oth_f, en_rel} <= 4'h0;
  endtask

  // Length of the active phase of reset (0) or restart wait (1), counted in clock cycles
  task automatic measure(input bit sel, input int ms);
    int n;
    int k;
    logic s;
    n = 0;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk);
      #1;
      s = sel ? restart_wait : !rst_out_n;
      if (s === 1'b1) n++;
      else if (n > 0) break;
    end
    check({7'h0, n >= (ms - 1) * TICK && n <= ms * TICK + 4}, 8'h01);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Reset values, address select, check-byte enable, read-only bits
  task automatic t_regs();
    u_reg_master_model.rd(8'h7c, rdv, vld);
    check(rdv, IFACE_OPT_RESET);
    check({7'h0, vld}, 8'h01);
    check({1'b0, bus_address}, 8'h4d);
    u_reg_master_model.wr(8'h7c, 8'h90);
    check({1'b0, bus_address}, 8'h4e);
    check({7'h0, crc_enable}, 8'h01);
    u_reg_master_model.wr(8'h7c, 8'hff);
    u_reg_master_model.rd(8'h7c, rdv, vld);
    check(rdv, 8'hbf);
    check({7'h0, sequencer_disable}, 8'h00);
    u_reg_master_model.wr(8'h7d, 8'hff);
    u_reg_master_model.rd(8'h7d, rdv, vld);
    check(rdv, 8'hf3);
    u_reg_master_model.rd(8'h7e, rdv, vld);
    check(rdv, 8'h00);
    u_reg_master_model.wr(8'h67, 8'h05);
    check({4'h0, regulator_on}, 8'h0a);
  endtask

  // Factory load hands regulators to the enable register
  task automatic t_manual();
    @(posedge clk);
    otp_iface <= 8'h40;
    otp_load  <= 1'b1;
    @(posedge clk);
    otp_load  <= 1'b0;
    hold(1);
    check({7'h0, sequencer_disable}, 8'h01);
    u_reg_master_model.wr(8'h67, 8'h05);
    check({4'h0, regulator_on}, 8'h05);
    @(posedge clk);
    otp_iface <= 8'h00;
    otp_load  <= 1'b1;
    @(posedge clk);
    otp_load  <= 1'b0;
    hold(1);
    check({4'h0, regulator_on}, 8'h0a);
  endtask

  // Every code of the threshold, limit and ignore fields
  task automatic t_decode();
    int c;
    hv_limit_t hv [4];
    lv_limit_t lv [4];
    hv = '{HV_LIM_1P50, HV_LIM_1P20, HV_LIM_1P75, HV_LIM_1P20};
    lv = '{LV_LIM_1P20, LV_LIM_1P20, LV_LIM_0P96, LV_LIM_1P56};
    for (c = 0; c < 8; c++) begin
      u_reg_master_model.wr(8'h7c, {5'h0, c[2:0]});
      u_reg_master_model.wr(8'h7d, {c[1:0], c[1:0], 2'h0, c[1:0]});
      @(posedge clk);
      seq_option <= c[2];
      hold(1);
      check({7'h0, neg_sel}, {7'h0, c[2]});
      check({6'h0, first_limit}, {6'h0, hv[c[1:0]]});
      check({6'h0, lim2}, {6'h0, lv[c[1:0]]});
      check({6'h0, lim3}, {6'h0, lv[c[1:0]]});
      check({4'h0, power_good_ignore}, {4'h0, PGM[c]});
    end
    @(posedge clk);
    seq_option <= 1'b0;
  endtask

  // Reset pulse and wait lengths
  task automatic t_faults();
    u_reg_master_model.wr(8'h7c, 8'h00);
    fire(2);
    measure(1'b0, 200);
    fire(0);
    measure(1'b0, 200);
    fire(3);
    measure(1'b1, 200);
    u_reg_master_model.wr(8'h7c, 8'h08);
    fire(0);
    measure(1'b0, 20);
    fire(1);
    measure(1'b1, 20);
    fire(2);
    measure(1'b0, 200);
    fire(3);
    measure(1'b1, 20);
  endtask

  // Window faults, ignore mask, filter and shutdown
  task automatic t_window();
    u_reg_master_model.wr(8'h7c, 8'h20);
    u_reg_master_model.wr(8'h7d, 8'h01);
    @(posedge clk);
    power_good <= 4'h7;
    hold(40);
    check({7'h0, rst_out_n}, 8'h01);
    @(posedge clk);
    power_good <= 4'hf;
    output_shutdown <= 1'b1;
    hold(4);
    check({7'h0, rst_out_n}, 8'h00);
    @(posedge clk);
    output_shutdown <= 1'b0;
    hold(4);
    @(posedge clk);
    power_good <= 4'hd;
    hold(108);
    check({7'h0, rst_out_n}, 8'h01);
    hold(20);
    check({7'h0, rst_out_n}, 8'h00);
    @(posedge clk);
    power_good <= 4'hf;
    u_reg_master_model.wr(8'h7c, 8'h00);
    @(posedge clk);
    power_good <= 4'hd;
    hold(4);
    check({7'h0, rst_out_n}, 8'h00);
    @(posedge clk);
    power_good <= 4'hf;
  endtask

  // ==========================================================================
  // Timeout and main sequence
  // ==========================================================================
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    otp_load = 1'b0;
    otp_iface = 8'h00;
    otp_cur = 8'h00;
    seq_option = 1'b0;
    power_good = 4'hf;
    output_shutdown = 1'b0;
    seq_on = 4'ha;
    {wdt, seq_f, oth_f, en_rel} = 4'h0;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    hold(1);
    check({7'h0, rst_out_n}, 8'h01);
    t_regs();
    t_manual();
    t_decode();
    t_faults();
    t_window();
    results();
  end
endmodule // test_option_registers

`default_nettype wire
